// File: verilog/tlic_ctrl.sv
// two level interrupt controller with apb register access
`timescale 1ns/100ps
`default_nettype none
module tlic_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] ext_pin,
    input wire logic [3:0] upper_port_nibble,
    input wire logic port_b_read,
    input wire logic timer_zero_overflow,
    input wire logic periph_high_req,
    input wire logic periph_low_req,
    input wire logic cycle_end,
    input wire logic return_from_service,
    output logic vector_load,
    output logic [20:0] vector_addr,
    output logic return_push,
    output logic port_pullup_disable
);
    logic [7:0] main_ctl;
    logic [7:0] edge_ctl;
    logic [7:0] ext_ctl;
    logic priority_mode_enable;
    logic [3:0] pin_meta, pin_sync, pin_prev;
    logic [3:0] nib_meta, nib_sync, nib_latch;
    logic [1:0] lat_cnt;
    logic lat_busy;
    logic lat_high;
    logic stack_low;
    tlic_pkg::tlic_state_e state;

    // apb decode
    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && penable && !pwrite;
    wire sel_main = paddr == tlic_pkg::REG_MAIN_OFS;
    wire sel_edge = paddr == tlic_pkg::REG_EDGE_OFS;
    wire sel_ext = paddr == tlic_pkg::REG_EXT_OFS;
    wire sel_rc = paddr == tlic_pkg::REG_RESET_CTRL_OFS;
    wire sel_st = paddr == tlic_pkg::REG_STATUS_OFS;
    wire mapped = sel_main | sel_edge | sel_ext | sel_rc | sel_st;

    // edge detection on synchronised pins
    // pin 0 selects from the top bit of the field, so the order is reversed
    wire [3:0] edge_sel = {edge_ctl[tlic_pkg::EDGE_SEL_LSB],
        edge_ctl[tlic_pkg::EDGE_SEL_LSB + 1],
        edge_ctl[tlic_pkg::EDGE_SEL_LSB + 2],
        edge_ctl[tlic_pkg::EDGE_SEL_LSB + 3]};
    wire [3:0] rise = pin_sync & ~pin_prev;
    wire [3:0] fall = ~pin_sync & pin_prev;
    wire [3:0] ext_evt = (edge_sel & rise) | (~edge_sel & fall);
    wire nib_mismatch = nib_sync != nib_latch;

    // per-source flag, enable, priority
    wire [4:0] flg = {main_ctl[tlic_pkg::MAIN_T0IF],
        main_ctl[tlic_pkg::MAIN_X0IF], main_ctl[tlic_pkg::MAIN_PCIF],
        ext_ctl[tlic_pkg::EXT_IF_LSB +: 2]};
    wire [4:0] ena = {main_ctl[tlic_pkg::MAIN_T0IE],
        main_ctl[tlic_pkg::MAIN_X0IE], main_ctl[tlic_pkg::MAIN_PCIE],
        ext_ctl[tlic_pkg::EXT_IE_LSB +: 2]};
    // external 0 is always high priority
    wire [4:0] pri = {edge_ctl[tlic_pkg::EDGE_T0IP], 1'b1,
        edge_ctl[tlic_pkg::EDGE_PCIP], ext_ctl[tlic_pkg::EXT_X2IP],
        ext_ctl[tlic_pkg::EXT_X1IP]};
    wire x3_act = ext_ctl[tlic_pkg::EXT_IF_LSB + 2]
        && ext_ctl[tlic_pkg::EXT_IE_LSB + 2];
    wire x3_pri = edge_ctl[tlic_pkg::EDGE_X3IP];
    wire [4:0] act = flg & ena;
    wire core_hi = |(act & pri) || (x3_act && x3_pri);
    wire core_lo = |(act & ~pri) || (x3_act && !x3_pri);
    wire global_enable = main_ctl[tlic_pkg::MAIN_GIE];
    wire peripheral_enable = main_ctl[tlic_pkg::MAIN_PERIPHERAL_ENABLE];

    // request lines
    wire req_high = priority_mode_enable
        ? global_enable && (core_hi || periph_high_req)
        : global_enable && (core_hi || core_lo || (peripheral_enable
            && (periph_high_req || periph_low_req)));
    wire req_low = priority_mode_enable && global_enable && peripheral_enable
        && (core_lo || periph_low_req);
    wire take_high = req_high && state != tlic_pkg::TLIC_IN_HIGH;
    wire take_low = req_low && state == tlic_pkg::TLIC_IDLE;
    wire take = (take_high || take_low) && !lat_busy;

    function automatic logic [7:0] wsel(input logic hit,
        input logic [7:0] cur);
        wsel = (wr_en && hit) ? pwdata[7:0] : cur;
    endfunction

    logic [7:0] next_main, next_ext;
    always_comb begin
        next_main = wsel(sel_main, main_ctl);
        next_ext = wsel(sel_ext, ext_ctl);
        // hardware sets win over a software clear
        if (timer_zero_overflow) begin
            next_main[tlic_pkg::MAIN_T0IF] = 1'b1;
        end
        if (ext_evt[0]) begin
            next_main[tlic_pkg::MAIN_X0IF] = 1'b1;
        end
        if (nib_mismatch) begin
            next_main[tlic_pkg::MAIN_PCIF] = 1'b1;
        end
        next_ext[tlic_pkg::EXT_IF_LSB +: 3] =
            next_ext[tlic_pkg::EXT_IF_LSB +: 3] | ext_evt[3:1];
        if (lat_busy && lat_cnt == 2'd0 && cycle_end) begin
            // accept clears the enable in use
            if (!priority_mode_enable || lat_high) begin
                next_main[tlic_pkg::MAIN_GIE] = 1'b0;
            end else begin
                next_main[tlic_pkg::MAIN_PERIPHERAL_ENABLE] = 1'b0;
            end
        end
        if (return_from_service && state != tlic_pkg::TLIC_IDLE) begin
            if (!priority_mode_enable || state == tlic_pkg::TLIC_IN_HIGH)
            begin
                next_main[tlic_pkg::MAIN_GIE] = 1'b1;
            end else begin
                next_main[tlic_pkg::MAIN_PERIPHERAL_ENABLE] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            main_ctl <= tlic_pkg::MAIN_RESET;
            edge_ctl <= tlic_pkg::EDGE_RESET;
            ext_ctl <= tlic_pkg::EXT_RESET;
            priority_mode_enable <= 1'b0;
        end else begin
            main_ctl <= next_main;
            edge_ctl <= wsel(sel_edge, edge_ctl);
            ext_ctl <= next_ext;
            if (wr_en && sel_rc) begin
                priority_mode_enable <= pwdata[tlic_pkg::RESET_CTRL_PRIORITY_MODE_ENABLE];
            end
        end
    end

    // two flop synchronisers for pins and port nibble
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            pin_prev <= 4'h0;
            nib_meta <= 4'h0;
            nib_sync <= 4'h0;
            nib_latch <= 4'h0;
        end else begin
            pin_meta <= ext_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            nib_meta <= upper_port_nibble;
            nib_sync <= nib_meta;
            if (port_b_read) begin
                nib_latch <= nib_sync;
            end
        end
    end

    // latency: accept waits two instruction-cycle ends after request,
    // so the delay does not depend on instruction length
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lat_busy <= 1'b0;
            lat_cnt <= 2'd0;
            lat_high <= 1'b0;
            state <= tlic_pkg::TLIC_IDLE;
            stack_low <= 1'b0;
            vector_load <= 1'b0;
            return_push <= 1'b0;
            vector_addr <= 21'h000000;
        end else begin
            vector_load <= 1'b0;
            return_push <= 1'b0;
            if (take) begin
                lat_busy <= 1'b1;
                lat_cnt <= 2'd1;
                lat_high <= take_high;
            end else if (lat_busy && cycle_end) begin
                if (lat_cnt != 2'd0) begin
                    lat_cnt <= lat_cnt - 2'd1;
                end else begin
                    lat_busy <= 1'b0;
                    vector_load <= 1'b1;
                    return_push <= 1'b1;
                    vector_addr <= lat_high ? tlic_pkg::HIGH_VECTOR
                        : tlic_pkg::LOW_VECTOR;
                    stack_low <= state == tlic_pkg::TLIC_IN_LOW;
                    state <= lat_high ? tlic_pkg::TLIC_IN_HIGH
                        : tlic_pkg::TLIC_IN_LOW;
                end
            end else if (return_from_service) begin
                case (state)
                    tlic_pkg::TLIC_IN_HIGH: begin
                        state <= stack_low ? tlic_pkg::TLIC_IN_LOW
                            : tlic_pkg::TLIC_IDLE;
                        stack_low <= 1'b0;
                    end
                    default: state <= tlic_pkg::TLIC_IDLE;
                endcase
            end
        end
    end

    // apb answer, zero wait states
    logic [7:0] rd_byte;
    assign rd_byte = sel_main ? main_ctl : sel_edge ? edge_ctl
        : sel_ext ? ext_ctl
        : sel_rc ? {priority_mode_enable, 7'h00}
        : sel_st ? {5'h00, lat_busy, state} : 8'h00;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            port_pullup_disable <= 1'b1;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable) ? {24'h000000, rd_byte} : prdata;
            port_pullup_disable <= edge_ctl[tlic_pkg::EDGE_PUDIS];
        end
    end

    piority_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load && !priority_mode_enable |->
        vector_addr == tlic_pkg::HIGH_VECTOR)
        else $error("compat mode vector not high");
    accept_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load && !priority_mode_enable |->
        !main_ctl[tlic_pkg::MAIN_GIE] || $past(return_from_service))
        else $error("global enable not cleared");
    push_pair_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load == return_push)
        else $error("push without vector");
    pullup_follow_a: assert property (@(posedge core_clk) disable iff (rst)
        port_pullup_disable == $past(edge_ctl[tlic_pkg::EDGE_PUDIS]))
        else $error("pullup disable wrong");
    flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
        timer_zero_overflow |=> main_ctl[tlic_pkg::MAIN_T0IF])
        else $error("timer flag missed");
    low_mask_a: assert property (@(posedge core_clk) disable iff (rst)
        !global_enable |-> !req_high && !req_low)
        else $error("request with global enable clear");
    high_vec_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load && state == tlic_pkg::TLIC_IN_HIGH
        |-> vector_addr == tlic_pkg::HIGH_VECTOR)
        else $error("high service wrong vector");
    pc_mismatch_a: assert property (@(posedge core_clk) disable iff (rst)
        nib_mismatch |=> main_ctl[tlic_pkg::MAIN_PCIF])
        else $error("port change flag not set");

    // vector handshake towards the core sequencer
    vec_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load |=> !vector_load)
        else $error("vector load longer than one cycle");
    low_vec_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load && state == tlic_pkg::TLIC_IN_LOW
        |-> vector_addr == tlic_pkg::LOW_VECTOR)
        else $error("low service wrong vector");
    vec_legal_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load |-> vector_addr == tlic_pkg::HIGH_VECTOR
        || vector_addr == tlic_pkg::LOW_VECTOR)
        else $error("vector outside the two fixed addresses");
    busy_vec_a: assert property (@(posedge core_clk) disable iff (rst)
        lat_busy && lat_cnt == 2'd0 && cycle_end |=> vector_load)
        else $error("accept did not vector");
    idle_novec_a: assert property (@(posedge core_clk) disable iff (rst)
        !lat_busy |=> !vector_load)
        else $error("vector without pending accept");

    // global and peripheral enables on entry and on return
    high_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load && state == tlic_pkg::TLIC_IN_HIGH
        |-> !main_ctl[tlic_pkg::MAIN_GIE] || $past(return_from_service))
        else $error("high enable not cleared");
    low_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        vector_load && state == tlic_pkg::TLIC_IN_LOW
        |-> !main_ctl[tlic_pkg::MAIN_PERIPHERAL_ENABLE] || $past(return_from_service))
        else $error("low enable not cleared");
    ret_high_a: assert property (@(posedge core_clk) disable iff (rst)
        return_from_service && state == tlic_pkg::TLIC_IN_HIGH
        |=> main_ctl[tlic_pkg::MAIN_GIE])
        else $error("high enable not restored");
    ret_low_a: assert property (@(posedge core_clk) disable iff (rst)
        return_from_service && priority_mode_enable
        && state == tlic_pkg::TLIC_IN_LOW |=> main_ctl[tlic_pkg::MAIN_PERIPHERAL_ENABLE])
        else $error("low enable not restored");

    // request lines and their gating
    compat_low_a: assert property (@(posedge core_clk) disable iff (rst)
        !priority_mode_enable |-> !req_low)
        else $error("low request in compatibility mode");
    compat_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        !priority_mode_enable && !peripheral_enable && !core_hi && !core_lo
        |-> !req_high)
        else $error("peripheral passed a clear peripheral enable");
    high_line_a: assert property (@(posedge core_clk) disable iff (rst)
        priority_mode_enable && global_enable && core_hi |-> req_high)
        else $error("high request line missing");
    low_line_a: assert property (@(posedge core_clk) disable iff (rst)
        priority_mode_enable && global_enable && peripheral_enable && periph_low_req |-> req_low)
        else $error("low request line missing");
    low_block_a: assert property (@(posedge core_clk) disable iff (rst)
        state != tlic_pkg::TLIC_IDLE |-> !take_low)
        else $error("low request taken during a service");
    preempt_a: assert property (@(posedge core_clk) disable iff (rst)
        state == tlic_pkg::TLIC_IN_LOW && req_high && !lat_busy |-> take)
        else $error("high request did not preempt low service");

    // flags, edges and mode bit
    ext_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        ext_evt[0] |=> main_ctl[tlic_pkg::MAIN_X0IF])
        else $error("external 0 flag missed");
    ext_one_a: assert property (@(posedge core_clk) disable iff (rst)
        ext_evt[1] |=> ext_ctl[tlic_pkg::EXT_IF_LSB])
        else $error("external 1 flag missed");
    ext_three_a: assert property (@(posedge core_clk) disable iff (rst)
        ext_evt[3] |=> ext_ctl[tlic_pkg::EXT_IF_LSB + 2])
        else $error("external 3 flag missed");
    edge_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        rise[0] && edge_ctl[tlic_pkg::EDGE_SEL_LSB + 3] |-> ext_evt[0])
        else $error("external 0 rising edge ignored");
    mode_write_a: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && sel_rc |=> priority_mode_enable
        == $past(pwdata[tlic_pkg::RESET_CTRL_PRIORITY_MODE_ENABLE]))
        else $error("priority mode bit not written");
endmodule
`default_nettype wire

// File: verilog/tlic_pkg.sv
// package for the two level interrupt controller
package tlic_pkg;
    localparam logic [7:0] REG_MAIN_OFS = 8'h00;
    localparam logic [7:0] REG_EDGE_OFS = 8'h04;
    localparam logic [7:0] REG_EXT_OFS = 8'h08;
    localparam logic [7:0] REG_RESET_CTRL_OFS = 8'h0C;
    localparam logic [7:0] REG_STATUS_OFS = 8'h10;
    localparam logic [7:0] MAIN_RESET = 8'h00;
    localparam logic [7:0] EDGE_RESET = 8'hFF;
    localparam logic [7:0] EXT_RESET = 8'hC0;
    localparam logic [20:0] HIGH_VECTOR = 21'h000008;
    localparam logic [20:0] LOW_VECTOR = 21'h000018;
    // main control register fields
    localparam int MAIN_GIE = 7;
    localparam int MAIN_PERIPHERAL_ENABLE = 6;
    localparam int MAIN_T0IE = 5;
    localparam int MAIN_X0IE = 4;
    localparam int MAIN_PCIE = 3;
    localparam int MAIN_T0IF = 2;
    localparam int MAIN_X0IF = 1;
    localparam int MAIN_PCIF = 0;
    // second control register fields
    localparam int EDGE_PUDIS = 7;
    localparam int EDGE_SEL_LSB = 3;
    localparam int EDGE_T0IP = 2;
    localparam int EDGE_X3IP = 1;
    localparam int EDGE_PCIP = 0;
    // third control register fields, then the reset control mode bit
    localparam int EXT_X2IP = 7;
    localparam int EXT_X1IP = 6;
    localparam int EXT_IE_LSB = 3;
    localparam int EXT_IF_LSB = 0;
    localparam int RESET_CTRL_PRIORITY_MODE_ENABLE = 7;

    typedef struct packed {
        logic valid;
        logic high;
        logic [20:0] vector;
    } tlic_vec_s;

    typedef enum logic [1:0] {
        TLIC_IDLE,
        TLIC_IN_LOW,
        TLIC_IN_HIGH
    } tlic_state_e;
endpackage

// File: sim/tlic_core_model.sv
// core sequencer and stack model facing the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic vector_load,
    input wire logic [20:0] vector_addr,
    input wire logic return_push,
    input wire logic do_return,
    output logic cycle_end,
    output logic return_from_service,
    output logic [7:0] vec_cnt,
    output logic [20:0] last_vec,
    output logic [4:0] depth
);
    logic [1:0] phase;
    // four clocks per instruction cycle, as on the real sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
            cycle_end <= 1'b0;
            return_from_service <= 1'b0;
            vec_cnt <= 8'h00;
            last_vec <= 21'h000000;
            depth <= 5'h00;
        end else begin
            phase <= phase + 2'h1;
            cycle_end <= (phase == 2'h3);
            return_from_service <= do_return;
            if (vector_load) begin
                vec_cnt <= vec_cnt + 8'h01;
                last_vec <= vector_addr;
            end
            // stack grows on push, shrinks on return
            if (return_push)
                depth <= depth + 5'h01;
            else if (do_return)
                depth <= depth - 5'h01;
        end
    end
endmodule
`default_nettype wire

// File: sim/test_two_level_interrupt_controller.sv
// self-checking bench for the two level interrupt controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
    failures++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end end
module test_two_level_interrupt_controller;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] ext_pin, nib;
    logic port_b_read, tmr, phr, plr, cycle_end, rfs, err, do_return;
    logic vector_load, return_push, port_pullup_disable;
    logic [20:0] vector_addr, last_vec;
    logic [7:0] vec_cnt;
    logic [4:0] depth;
    int failures, checks, lat;
    tlic_ctrl tlic_ctrl_i (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_pin(ext_pin), .upper_port_nibble(nib), .port_b_read(port_b_read),
        .timer_zero_overflow(tmr), .periph_high_req(phr),
        .periph_low_req(plr), .cycle_end(cycle_end),
        .return_from_service(rfs), .vector_load(vector_load),
        .vector_addr(vector_addr), .return_push(return_push),
        .port_pullup_disable(port_pullup_disable));
    tlic_core_model tlic_core_model_i (.core_clk(core_clk), .rst(rst),
        .vector_load(vector_load), .vector_addr(vector_addr),
        .return_push(return_push), .do_return(do_return),
        .cycle_end(cycle_end), .return_from_service(rfs),
        .vec_cnt(vec_cnt), .last_vec(last_vec), .depth(depth));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one apb transfer; holds the request until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            summarize();
        end
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] ex);
        apb(1'b0, a, 8'h00);
        `CHK("register", {24'h000000, ex}, rd)
        `CHK("slave error", 1'b0, err)
    endtask
    task wait_vec(input logic [20:0] ex, input logic [7:0] cnt);
        int n;
        n = 0;
        lat = 0;
        while (vec_cnt !== cnt && n < 300) begin
            @(posedge core_clk);
            n++;
            if (cycle_end === 1'b1)
                lat++;
        end
        if (vec_cnt !== cnt) begin
            failures++;
            summarize();
        end else begin
            `CHK("vector", ex, last_vec)
        end
    endtask
    task pulse_tmr;
        @(posedge core_clk);
        tmr <= 1'b1;
        @(posedge core_clk);
        tmr <= 1'b0;
        clk(4);
    endtask
    task ret;
        @(posedge core_clk);
        do_return <= 1'b1;
        @(posedge core_clk);
        do_return <= 1'b0;
        clk(3);
    endtask
    initial begin
        failures = 0;
        checks = 0;
        {rst, psel, penable, pwrite, paddr, pwdata} = {3'b100, 41'h0};
        {ext_pin, nib, port_b_read, tmr, phr, plr, do_return} = 13'h0;
        clk(10);
        rst <= 1'b0;
        rdchk(8'h00, 8'h00);
        rdchk(8'h04, 8'hFF);
        rdchk(8'h08, 8'hC0);
        rdchk(8'h0C, 8'h00);
        apb(1'b0, 8'h14, 8'h00);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h00000000, rd)
        `CHK("pullups off", 1'b1, port_pullup_disable)
        apb(1'b1, 8'h04, 8'h7F);
        clk(2);
        `CHK("pullups on", 1'b0, port_pullup_disable)
        apb(1'b1, 8'h04, 8'hFF);
        pulse_tmr();
        rdchk(8'h00, 8'h04);
        // compatibility mode: peripheral request waits for both enables
        plr <= 1'b1;
        apb(1'b1, 8'h00, 8'h80);
        clk(20);
        `CHK("masked count", 8'h00, vec_cnt)
        apb(1'b1, 8'h00, 8'hC0);
        wait_vec(21'h000008, 8'h01);
        plr <= 1'b0;
        rdchk(8'h00, 8'h40);
        ret();
        rdchk(8'h00, 8'hC0);
        `CHK("stack depth", 5'h00, depth)
        // priority mode: timer low, then ext 0 preempts
        apb(1'b1, 8'h0C, 8'h80);
        apb(1'b1, 8'h04, 8'hFB);
        apb(1'b1, 8'h00, 8'hE0);
        pulse_tmr();
        wait_vec(21'h000018, 8'h02);
        rdchk(8'h00, 8'hA4);
        apb(1'b1, 8'h00, 8'hB0);
        @(posedge core_clk);
        ext_pin[0] <= 1'b1;
        wait_vec(21'h000008, 8'h03);
        `CHK("latency", 1'b1, lat >= 3 && lat <= 4)
        `CHK("nested depth", 5'h02, depth)
        rdchk(8'h00, 8'h32);
        apb(1'b1, 8'h00, 8'h30);
        ret();
        rdchk(8'h00, 8'hB0);
        ret();
        rdchk(8'h00, 8'hF0);
        // low enable alone must not pass a request
        apb(1'b1, 8'h00, 8'h40);
        plr <= 1'b1;
        clk(20);
        `CHK("high enable mask", 8'h03, vec_cnt)
        apb(1'b1, 8'h00, 8'hC0);
        wait_vec(21'h000018, 8'h04);
        plr <= 1'b0;
        ret();
        // port change keeps re-setting until port b is read
        apb(1'b1, 8'h00, 8'h00);
        nib <= 4'h5;
        clk(10);
        rdchk(8'h00, 8'h01);
        apb(1'b1, 8'h00, 8'h00);
        rdchk(8'h00, 8'h01);
        @(posedge core_clk);
        port_b_read <= 1'b1;
        @(posedge core_clk);
        port_b_read <= 1'b0;
        apb(1'b1, 8'h00, 8'h00);
        rdchk(8'h00, 8'h00);
        for (int i = 1; i < 4; i++)
            ext_pin[i] <= 1'b1;
        clk(10);
        rdchk(8'h08, 8'hC7);
        apb(1'b1, 8'h08, 8'hC0);
        apb(1'b1, 8'h04, 8'hDB);
        ext_pin[1] <= 1'b0;
        clk(10);
        rdchk(8'h08, 8'hC1);
        summarize();
    end
endmodule
`default_nettype wire
